/* File: logic/prpc_cfg.svh */
`ifndef PRPC_CFG_SVH
`define PRPC_CFG_SVH

// Register byte offsets
`define PRPC_OFS_CORE 6'h08
`define PRPC_OFS_PERIPH 6'h0c
`define PRPC_OFS_PERF 6'h10
`define PRPC_OFS_SRC 6'h04
`define PRPC_OFS_LOCK 6'h14

// Core reset control fields
`define PRPC_BIT_CHIP 0
`define PRPC_BIT_KERNEL 1
`define PRPC_BIT_DMA 2
`define PRPC_BIT_EXTBUS 3
`define PRPC_CORE_MASK 32'h0000000f

// Peripheral reset control: implemented bits
`define PRPC_PERIPH_MASK 32'h39f7f33e

// Performance control
`define PRPC_BIT_PERF 0
`define PRPC_PERF_MASK 32'h00000001

// Reset source flags
`define PRPC_BIT_POR_FLAG 0
`define PRPC_BIT_KERN_FLAG 7
`define PRPC_SRC_MASK 32'h00000081

// Unlock key sequence
`define PRPC_KEY0 8'h59
`define PRPC_KEY1 8'h16
`define PRPC_KEY2 8'h88

// One-shot pulse length in clock cycles
`define PRPC_ONESHOT_CYC 2

`define PRPC_RESET_VAL 32'h00000000

`endif

/* File: logic/prpc_ctrl.sv */
// Notes on behaviour
// - External bus reset held while its bit stays 1.
// - DMA controller reset held while its bit stays 1.
// - Kernel bit resets kernel and flash controller, clears after two cycles.
// - Chip bit resets kernel and peripherals, clears after two cycles.
// - Chip reset acts as power-on, reloading flash configuration.
// - Core reset bits writable only after key 59h,16h,88h unlocks.
// - Peripheral register bit at 1 holds that peripheral in reset.
// - Bits 29,28,27,24,23,22,21,20 map audio..lower PWM resets.
// - Serial port resets at bits 16-18, bit 19 reserved.
// - Sync serial at 12-15, two-wire at 8-9, 10-11 reserved.
// - Timers at 2-5, GPIO at 1; 0,6,7,30,31 reserved.
// - High-perf bit gives zero-wait RAM/GPIO and better flash prediction.
// - High-perf works at any clock, protected, 0 means normal.
// - Software kernel reset sets kernel source flag, write 1 clears.
// - Chip software reset sets the power-on source flag.
//
// Register access over Avalon-MM was chosen for this implementation.
`include "prpc_cfg.svh"

module prpc_ctrl
  import prpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Reset outputs
  output logic chip_reset_q,
  output logic kernel_reset_q,
  output logic flash_memory_controller_reset_q,
  output logic config_reload_q,
  output logic dma_ctrl_reset_q,
  output logic ext_bus_reset_q,
  output logic [31:0] periph_reset_q,
  // Performance control and unlock status
  output logic high_perf_enable_q,
  output logic unlocked_q
);
  logic [31:0] be_mask;
  logic acc_q;
  logic wr_go;
  logic rd_go;
  logic [1:0] core_q;
  logic [31:0] periph_q;
  logic perf_q;
  logic kern_flag_q;
  logic por_flag_q;
  logic chip_fire;
  logic kern_fire;
  logic chip_pulse;
  logic kern_pulse;
  prpc_key_t key_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] be,
                                        input logic [31:0] msk);
    merge = ((old & ~be) | (wd & be)) & msk;
  endfunction : merge

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle: request accepted on the second edge it is seen
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_mask[i*8 +: 8] = {8{byteenable[i]}};
    end
  end

  assign wr_go = write & acc_q;
  // Read data is latched on the first edge, so that it already stands
  // at the edge where the master samples waitrequest low
  assign rd_go = read & ~acc_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      acc_q <= (read | write) & ~acc_q;
      waitrequest <= ~((read | write) & ~acc_q);
    end
  end

  // ---------------------------------------------------------------
  // Unlock sequence
  // ---------------------------------------------------------------
  // Any other write to the lock address relocks and restarts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_q <= prpc_key_idle;
      unlocked_q <= 1'b0;
    end else if (chip_pulse) begin
      key_q <= prpc_key_idle;
      unlocked_q <= 1'b0;
    end else if (wr_go && address == `PRPC_OFS_LOCK && byteenable[0]) begin
      unlocked_q <= 1'b0;
      case (key_q)
        prpc_key_idle: begin
          key_q <= (writedata[7:0] == `PRPC_KEY0) ? prpc_key_got0
                                                  : prpc_key_idle;
        end
        prpc_key_got0: begin
          key_q <= (writedata[7:0] == `PRPC_KEY1) ? prpc_key_got1
                                                  : prpc_key_idle;
        end
        prpc_key_got1: begin
          key_q <= prpc_key_idle;
          unlocked_q <= (writedata[7:0] == `PRPC_KEY2);
        end
        default: begin
          key_q <= prpc_key_idle;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Core reset control
  // ---------------------------------------------------------------
  assign chip_fire = wr_go && unlocked_q && address == `PRPC_OFS_CORE &&
                     byteenable[0] && writedata[`PRPC_BIT_CHIP];
  assign kern_fire = wr_go && unlocked_q && address == `PRPC_OFS_CORE &&
                     byteenable[0] && writedata[`PRPC_BIT_KERNEL];

  prpc_oneshot u_chip_shot (
    .clk(clk),
    .rst(rst),
    .fire(chip_fire),
    .pulse_q(chip_pulse)
  );

  prpc_oneshot u_kern_shot (
    .clk(clk),
    .rst(rst),
    .fire(kern_fire),
    .pulse_q(kern_pulse)
  );

  // DMA and external bus are level resets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_q <= 2'h0;
    end else if (chip_pulse) begin
      core_q <= 2'h0;
    end else if (wr_go && unlocked_q && address == `PRPC_OFS_CORE &&
                 byteenable[0]) begin
      core_q <= writedata[`PRPC_BIT_EXTBUS:`PRPC_BIT_DMA];
    end
  end

  // Outputs registered; chip reset drives kernel and flash too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chip_reset_q <= 1'b0;
      kernel_reset_q <= 1'b0;
      flash_memory_controller_reset_q <= 1'b0;
      config_reload_q <= 1'b0;
      dma_ctrl_reset_q <= 1'b0;
      ext_bus_reset_q <= 1'b0;
    end else begin
      chip_reset_q <= chip_pulse;
      kernel_reset_q <= chip_pulse | kern_pulse;
      flash_memory_controller_reset_q <= chip_pulse | kern_pulse;
      config_reload_q <= chip_pulse;
      dma_ctrl_reset_q <= core_q[0] | chip_pulse;
      ext_bus_reset_q <= core_q[1] | chip_pulse;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral reset and performance
  // ---------------------------------------------------------------
  // A chip reset clears the register as a power-on would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_q <= `PRPC_RESET_VAL;
      periph_reset_q <= `PRPC_RESET_VAL;
      perf_q <= 1'b0;
      high_perf_enable_q <= 1'b0;
    end else begin
      if (chip_pulse) begin
        periph_q <= `PRPC_RESET_VAL;
        perf_q <= 1'b0;
      end else if (wr_go && address == `PRPC_OFS_PERIPH) begin
        periph_q <= merge(periph_q, writedata, be_mask,
                          `PRPC_PERIPH_MASK);
      end else if (wr_go && unlocked_q && address == `PRPC_OFS_PERF &&
                   byteenable[0]) begin
        perf_q <= writedata[`PRPC_BIT_PERF];
      end
      periph_reset_q <= periph_q |
                        ({32{chip_pulse}} & `PRPC_PERIPH_MASK);
      high_perf_enable_q <= perf_q;
    end
  end

  // ---------------------------------------------------------------
  // Reset source flags
  // ---------------------------------------------------------------
  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kern_flag_q <= 1'b0;
      por_flag_q <= 1'b1;
    end else begin
      if (kern_fire) begin
        kern_flag_q <= 1'b1;
      end else if (wr_go && address == `PRPC_OFS_SRC && byteenable[0] &&
                   writedata[`PRPC_BIT_KERN_FLAG]) begin
        kern_flag_q <= 1'b0;
      end
      if (chip_fire) begin
        por_flag_q <= 1'b1;
      end else if (wr_go && address == `PRPC_OFS_SRC && byteenable[0] &&
                   writedata[`PRPC_BIT_POR_FLAG]) begin
        por_flag_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (rd_go) begin
      case (address)
        `PRPC_OFS_SRC: begin
          readdata <= {24'h000000, kern_flag_q, 6'h00, por_flag_q};
        end
        `PRPC_OFS_CORE: begin
          readdata <= {28'h0000000, core_q, kern_pulse, chip_pulse};
        end
        `PRPC_OFS_PERIPH: begin
          readdata <= periph_q;
        end
        `PRPC_OFS_PERF: begin
          readdata <= {31'h00000000, perf_q};
        end
        `PRPC_OFS_LOCK: begin
          readdata <= {31'h00000000, unlocked_q};
        end
        default: begin
          readdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule : prpc_ctrl

/* File: logic/prpc_oneshot.sv */
`include "prpc_cfg.svh"

module prpc_oneshot (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Trigger and pulse
  input wire logic fire,
  output logic pulse_q
);
  logic [1:0] cnt_q;

  // Bit holds for a fixed count then clears itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      pulse_q <= 1'b0;
    end else if (fire) begin
      cnt_q <= 2'(`PRPC_ONESHOT_CYC - 1);
      pulse_q <= 1'b1;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end else begin
      pulse_q <= 1'b0;
    end
  end
endmodule : prpc_oneshot

/* File: logic/prpc_pkg.sv */
package prpc_pkg;
  typedef enum logic [1:0] {
    prpc_key_idle,
    prpc_key_got0,
    prpc_key_got1
  } prpc_key_t;
endpackage : prpc_pkg

/* File: testbench/prpc_ctrl_monitor.sv */
module prpc_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reset and mode outputs
  input wire logic chip_reset_q,
  input wire logic kernel_reset_q,
  input wire logic flash_memory_controller_reset_q,
  input wire logic config_reload_q,
  input wire logic [31:0] periph_reset_q,
  input wire logic high_perf_enable_q,
  input wire logic unlocked_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_kernel_two_cycles: assert property ($rose(kernel_reset_q) |->
    kernel_reset_q ##1 kernel_reset_q ##1 !kernel_reset_q)
    else $error("kernel pulse length");
  a_chip_two_cycles: assert property ($rose(chip_reset_q) |->
    chip_reset_q ##1 chip_reset_q ##1 !chip_reset_q)
    else $error("chip pulse length");
  a_chip_hits_kernel: assert property
    (chip_reset_q |-> kernel_reset_q)
    else $error("chip pulse without kernel");
  a_reload_with_chip: assert property
    (config_reload_q == chip_reset_q)
    else $error("reload not with chip");
  a_flash_with_kernel: assert property
    (flash_memory_controller_reset_q == kernel_reset_q)
    else $error("flash reset apart from kernel");
  a_kernel_spares_periph: assert property
    ($rose(kernel_reset_q) && !chip_reset_q |=> $stable(periph_reset_q))
    else $error("kernel reset touched peripherals");
  a_reserved_stay_zero: assert property
    ((periph_reset_q & ~32'h39f7f33e) == 32'h0)
    else $error("reserved peripheral bit set");
  a_perf_needs_key: assert property
    ($rose(high_perf_enable_q) |-> $past(unlocked_q, 2))
    else $error("perf bit set while locked");
  c_chip: cover property ($rose(chip_reset_q));
  c_kernel: cover property ($rose(kernel_reset_q) && !chip_reset_q);
  c_perf: cover property ($rose(high_perf_enable_q));
endmodule : prpc_ctrl_monitor

bind prpc_ctrl prpc_ctrl_monitor mon (.clk(clk), .rst(rst),
  .chip_reset_q(chip_reset_q), .kernel_reset_q(kernel_reset_q),
  .flash_memory_controller_reset_q(flash_memory_controller_reset_q),
  .config_reload_q(config_reload_q), .periph_reset_q(periph_reset_q),
  .high_perf_enable_q(high_perf_enable_q), .unlocked_q(unlocked_q));

/* File: testbench/prpc_periph_model.sv */
module prpc_periph_model (
  // Resets from the block
  input wire logic kernel_reset_q,
  input wire logic [31:0] periph_reset_q,
  // Observed state
  output int boots,
  output logic [31:0] held
);
  timeunit 1ns;
  timeprecision 1ps;
  // Kernel restarts once per pulse, however long the pulse lasts
  initial boots = 0;
  always @(posedge kernel_reset_q) boots++;
  // Asynchronous hold: no clock is involved
  assign held = periph_reset_q;
endmodule : prpc_periph_model

/* File: testbench/testbench.sv */
`include "prpc_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fail_count++; $display("wrong value %0t %h %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, read, write, waitrequest, chip, kern, dma, ext, perf, unl;
  logic [5:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, periph, held, rv;
  int fail_count, check_count, boots, kc, cc, b0;
  prpc_ctrl dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .chip_reset_q(chip),
    .kernel_reset_q(kern), .flash_memory_controller_reset_q(),
    .config_reload_q(), .dma_ctrl_reset_q(dma), .ext_bus_reset_q(ext),
    .periph_reset_q(periph), .high_perf_enable_q(perf), .unlocked_q(unl));
  prpc_periph_model far (.kernel_reset_q(kern), .periph_reset_q(periph),
    .boots(boots), .held(held));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    kc += kern;
    cc += chip;
  end
  task complete_run;
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // Request held until the edge that sees waitrequest low
  task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) fail_count++;
    rv = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // Registered outputs settle before the caller looks at them
    @(negedge clk);
  endtask : acc
  task t_lock;
    acc(1, `PRPC_OFS_CORE, 32'hf);
    acc(1, `PRPC_OFS_PERF, 32'h1);
    repeat (4) @(negedge clk);
    `CHK({dma, ext, perf, chip}, 4'h0)
    acc(0, `PRPC_OFS_CORE, 0);
    `CHK(rv, 32'h0)
    acc(1, `PRPC_OFS_LOCK, `PRPC_KEY0);
    acc(1, `PRPC_OFS_LOCK, `PRPC_KEY1);
    acc(1, `PRPC_OFS_LOCK, `PRPC_KEY2);
    `CHK(unl, 1'b1)
  endtask : t_lock
  task t_levels;
    acc(1, `PRPC_OFS_CORE, 32'hc);
    repeat (8) @(negedge clk);
    `CHK(ext, 1'b1)
    `CHK(dma, 1'b1)
    acc(1, `PRPC_OFS_CORE, 32'h8);
    repeat (2) @(negedge clk);
    `CHK({dma, ext}, 2'b01)
    acc(1, `PRPC_OFS_CORE, 0);
    repeat (2) @(negedge clk);
    `CHK(ext, 1'b0)
  endtask : t_levels
  task t_kernel;
    kc = 0;
    cc = 0;
    b0 = boots;
    acc(1, `PRPC_OFS_CORE, 32'h2);
    repeat (6) @(negedge clk);
    `CHK({kc, cc, boots}, {32'd2, 32'd0, b0 + 1})
    acc(0, `PRPC_OFS_CORE, 0);
    `CHK(rv, 32'h0)
    acc(0, `PRPC_OFS_SRC, 0);
    `CHK(rv[7], 1'b1)
    acc(1, `PRPC_OFS_SRC, 32'h80);
    acc(0, `PRPC_OFS_SRC, 0);
    `CHK(rv[7], 1'b0)
  endtask : t_kernel
  task t_periph_perf;
    acc(1, `PRPC_OFS_PERIPH, 32'hffffffff);
    @(negedge clk);
    `CHK(held, 32'h39f7f33e)
    acc(0, `PRPC_OFS_PERIPH, 0);
    `CHK(rv, 32'h39f7f33e)
    byteenable <= 4'h1;
    acc(1, `PRPC_OFS_PERIPH, 0);
    @(negedge clk);
    `CHK(held, 32'h39f7f300)
    byteenable <= 4'hf;
    acc(1, `PRPC_OFS_PERF, 32'hffffffff);
    repeat (3) @(negedge clk);
    `CHK(perf, 1'b1)
    acc(0, `PRPC_OFS_PERF, 0);
    `CHK(rv, 32'h1)
  endtask : t_periph_perf
  task t_chip;
    acc(1, `PRPC_OFS_SRC, 32'h1);
    kc = 0;
    cc = 0;
    acc(1, `PRPC_OFS_CORE, 32'h1);
    repeat (6) @(negedge clk);
    `CHK({cc, kc}, {32'd2, 32'd2})
    `CHK({held, perf}, 33'h0)
    acc(0, `PRPC_OFS_SRC, 0);
    `CHK(rv[0], 1'b1)
  endtask : t_chip
  initial begin
    rst = 1;
    {read, write, address, writedata, byteenable} = {40'h0, 4'hf};
    fail_count = 0;
    check_count = 0;
    kc = 0;
    cc = 0;
    repeat (4) @(posedge clk);
    rst <= 0;
    for (int i = 2; i < 6; i++) begin
      acc(0, 6'(i * 4), 0);
      `CHK(rv, 32'h0)
    end
    t_lock;
    t_levels;
    t_kernel;
    t_periph_perf;
    t_chip;
    complete_run;
  end
  initial begin
    #20000;
    fail_count++;
    complete_run;
  end
endmodule : testbench
